// ### dsocr_pkg.sv
// Package: offsets, fields and reset values of the shared output configuration registers
package dsocr_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] INT_CTL_OFS       = 8'h23;
  localparam logic [7:0] INT_STS_OFS       = 8'h24;
  localparam logic [7:0] FRAME_TRIG_OFS    = 8'h25;
  localparam logic [7:0] RSVD_A_LO_OFS     = 8'h26;
  localparam logic [7:0] RSVD_A_HI_OFS     = 8'h3a;
  localparam logic [7:0] OUT_CLK_EDGE_OFS  = 8'h3b;
  localparam logic [7:0] CLK_LOW_THR_OFS   = 8'h3c;
  localparam logic [7:0] SPREAD_CTRL_OFS   = 8'h3e;
  localparam logic [7:0] RSVD_B_LO_OFS     = 8'h44;
  localparam logic [7:0] RSVD_B_HI_OFS     = 8'h4b;
  localparam logic [7:0] PORT_STS_FIRST_OFS  = 8'h4d;
  localparam logic [7:0] PORT_STS_SECOND_OFS = 8'h4e;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PORT_ZERO_BIT   = 0;
  localparam int PORT_ONE_BIT    = 1;
  localparam int GLOBAL_IRQ_BIT  = 7;
  localparam int TRIG_EDGE_BIT   = 6;
  localparam int CLK_EDGE_BIT    = 0;
  localparam int SPREAD_ON_BIT   = 4;
  localparam int SPREAD_RATE_BIT = 0;
  localparam int LOW_LIMIT_W     = 5;
  // ------------------------------------------------------------
  // Reset values and spread profile
  // ------------------------------------------------------------
  localparam logic                   CLK_EDGE_RST  = 1'b1;
  localparam logic [LOW_LIMIT_W-1:0] LOW_LIMIT_RST = 5'h14;
  localparam int                     SPREAD_DIV    = 3168;
  localparam int                     SPREAD_DEV_PCT = 1;

  typedef struct packed {
    logic                   frame_trigger_edge_sel;
    logic                   output_clock_edge_sel;
    logic [LOW_LIMIT_W-1:0] recovered_clock_low_limit;
    logic                   spread_modulation_on;
    logic                   spread_modulation_rate;
    logic                   spread_profile_valid;
    logic                   port_zero_irq_enable;
    logic                   port_one_irq_enable;
    logic                   global_irq_enable;
  } dsocr_cfg_type;
endpackage

// ### dsocr_regs.sv
// Shared output configuration and per-port interrupt status register bank
//
// Behaviour
// - Port-one flag sets on port-one event, clears on reading its status registers.
// - Port-zero flag sets on port-zero event, clears on reading its status registers.
// - Bit 6 selects frame trigger edge: zero rising, one falling.
// - Output clock edge bit default one: drive falling; zero: drive rising.
// - Bits 4:0, reset 0x14, hold recovered-clock low limit in MHz.
// - Spread control bit 4 enables modulation; resets disabled.
// - Rate zero reserved; rate one modulates at pixel clock/3168, +/-1%.
// - Global status bit set when any port flag and its enable both set.
//
// Implementation choice: the strobed register port.
module dsocr_regs
  import dsocr_pkg::*;
#(
  parameter int ADDR_W = 8, // Register address width
  parameter int DATA_W = 8  // Register data width
)
(
  input  wire logic              MCLK,          // Core clock, 100 MHz
  input  wire logic              SYS_RST,       // Async reset, active high
  input  wire logic [ADDR_W-1:0] ADDR,          // Register address
  input  wire logic [DATA_W-1:0] WDATA,         // Write data
  input  wire logic              WR,            // Write strobe
  input  wire logic              RD,            // Read strobe
  output logic      [DATA_W-1:0] RDATA,         // Read data, cycle after RD
  input  wire logic              PORT0_EVENT,   // Port zero interrupt event pulse
  input  wire logic              PORT1_EVENT,   // Port one interrupt event pulse
  input  wire logic              STS_READ_PORT, // Port whose status registers RD selects
  output dsocr_cfg_type          CFG,           // Configuration to core logic
  output logic                   GLOBAL_IRQ     // Global status, enable-gated
);

  // ------------------------------------------------------------
  // State and next values
  // ------------------------------------------------------------
  logic                   port_zero_irq_flag_q;
  logic                   port_zero_irq_flag_d;
  logic                   port_one_irq_flag_q;
  logic                   port_one_irq_flag_d;

  logic                   trig_edge_q;
  logic                   clk_edge_q;
  logic [LOW_LIMIT_W-1:0] low_limit_q;
  logic                   spread_on_q;
  logic                   spread_rate_q;
  logic [1:0]             ie_q;
  logic                   gie_q;

  logic [DATA_W-1:0]      rdata_q;
  logic [7:0]             rdata_d;

  // ------------------------------------------------------------
  // Decoded strobes and register images
  // ------------------------------------------------------------
  logic                   wr_int_ctl;
  logic                   wr_frame_trig;
  logic                   wr_clk_edge;
  logic                   wr_low_limit;
  logic                   wr_spread;
  logic                   sts_rd;
  logic                   sts_rd_port0;
  logic                   sts_rd_port1;
  logic                   rsvd_hit;
  logic                   irq0_pending;
  logic                   irq1_pending;
  logic                   global_sts;
  logic                   spread_profile_ok;
  logic [7:0]             img_int_ctl;
  logic [7:0]             img_int_sts;
  logic [7:0]             img_frame_trig;
  logic [7:0]             img_clk_edge;
  logic [7:0]             img_low_limit;
  logic [7:0]             img_spread;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Offsets and field positions are fixed at eight bits
  if (ADDR_W != 8) begin : g_bad_addr_w
    $error("dsocr_regs needs an eight-bit address");
  end

  if (DATA_W != 8) begin : g_bad_data_w
    $error("dsocr_regs needs eight-bit data");
  end

  if (LOW_LIMIT_W > 8) begin : g_bad_limit_w
    $error("dsocr_regs low limit must fit one byte");
  end

  if (GLOBAL_IRQ_BIT > 7 || TRIG_EDGE_BIT > 7 || SPREAD_ON_BIT > 7) begin : g_bad_bit
    $error("dsocr_regs field position outside the byte");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // One register image bit; reserved positions stay zero
  function automatic logic [7:0] put_bit(input int pos, input logic v);
    logic [7:0] r;
    r      = 8'h00;
    r[pos] = v;
    return r;
  endfunction

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  assign wr_int_ctl    = WR && hit(ADDR, INT_CTL_OFS);
  assign wr_frame_trig = WR && hit(ADDR, FRAME_TRIG_OFS);
  assign wr_clk_edge   = WR && hit(ADDR, OUT_CLK_EDGE_OFS);
  assign wr_low_limit  = WR && hit(ADDR, CLK_LOW_THR_OFS);
  assign wr_spread     = WR && hit(ADDR, SPREAD_CTRL_OFS);

  // Either status register read clears; the select picks the port
  assign sts_rd       = RD && (hit(ADDR, PORT_STS_FIRST_OFS) || hit(ADDR, PORT_STS_SECOND_OFS));
  assign sts_rd_port0 = sts_rd && !STS_READ_PORT;
  assign sts_rd_port1 = sts_rd && STS_READ_PORT;

  // Reserved ranges answer zero and hold no storage
  assign rsvd_hit = in_range(ADDR, RSVD_A_LO_OFS, RSVD_A_HI_OFS) ||
                    in_range(ADDR, RSVD_B_LO_OFS, RSVD_B_HI_OFS);

  // ------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------
  // Set wins over the clearing read so an event is never lost
  always_comb begin
    port_zero_irq_flag_d = port_zero_irq_flag_q;
    if (PORT0_EVENT) begin
      port_zero_irq_flag_d = 1'b1;
    end else if (sts_rd_port0) begin
      port_zero_irq_flag_d = 1'b0;
    end
  end

  always_comb begin
    port_one_irq_flag_d = port_one_irq_flag_q;
    if (PORT1_EVENT) begin
      port_one_irq_flag_d = 1'b1;
    end else if (sts_rd_port1) begin
      port_one_irq_flag_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      port_zero_irq_flag_q <= 1'b0;
    end else begin
      port_zero_irq_flag_q <= port_zero_irq_flag_d;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      port_one_irq_flag_q <= 1'b0;
    end else begin
      port_one_irq_flag_q <= port_one_irq_flag_d;
    end
  end

  // Independent of the global enable
  assign irq0_pending = port_zero_irq_flag_q && ie_q[0];
  assign irq1_pending = port_one_irq_flag_q && ie_q[1];
  assign global_sts   = irq0_pending || irq1_pending;
  assign GLOBAL_IRQ   = global_sts;

  // ------------------------------------------------------------
  // Writable configuration
  // ------------------------------------------------------------
  // Enables live here so the status image can gate on them
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ie_q  <= 2'b00;
      gie_q <= 1'b0;
    end else if (wr_int_ctl) begin
      ie_q  <= {WDATA[PORT_ONE_BIT], WDATA[PORT_ZERO_BIT]};
      gie_q <= WDATA[GLOBAL_IRQ_BIT];
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      trig_edge_q <= 1'b0;
    end else if (wr_frame_trig) begin
      trig_edge_q <= WDATA[TRIG_EDGE_BIT];
    end
  end

  // Default one drives data on the falling pixel clock edge
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      clk_edge_q <= CLK_EDGE_RST;
    end else if (wr_clk_edge) begin
      clk_edge_q <= WDATA[CLK_EDGE_BIT];
    end
  end

  // Threshold in MHz for the too-slow clock detector
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_limit_q <= LOW_LIMIT_RST;
    end else if (wr_low_limit) begin
      low_limit_q <= WDATA[LOW_LIMIT_W-1:0];
    end
  end

  // Rate and enable take a single write as given; ordering is software's job
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      spread_on_q   <= 1'b0;
      spread_rate_q <= 1'b0;
    end else if (wr_spread) begin
      spread_on_q   <= WDATA[SPREAD_ON_BIT];
      spread_rate_q <= WDATA[SPREAD_RATE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Spread profile
  // ------------------------------------------------------------
  // Reserved rate zero never yields a profile; the divider itself
  // lives in the clock generator, which only sees this qualifier
  assign spread_profile_ok = spread_on_q && spread_rate_q;

  // ------------------------------------------------------------
  // Outputs to core
  // ------------------------------------------------------------
  always_comb begin
    CFG                           = '0;
    CFG.frame_trigger_edge_sel    = trig_edge_q;
    CFG.output_clock_edge_sel     = clk_edge_q;
    CFG.recovered_clock_low_limit = low_limit_q;
    CFG.spread_modulation_on      = spread_on_q;
    CFG.spread_modulation_rate    = spread_rate_q;
    CFG.spread_profile_valid      = spread_profile_ok;
    CFG.port_zero_irq_enable      = ie_q[0];
    CFG.port_one_irq_enable       = ie_q[1];
    CFG.global_irq_enable         = gie_q;
  end

  // ------------------------------------------------------------
  // Register images
  // ------------------------------------------------------------
  // Reserved bits of every image stay zero
  always_comb begin
    img_int_ctl    = put_bit(GLOBAL_IRQ_BIT, gie_q) |
                     put_bit(PORT_ONE_BIT, ie_q[1]) |
                     put_bit(PORT_ZERO_BIT, ie_q[0]);
    img_int_sts    = put_bit(GLOBAL_IRQ_BIT, global_sts) |
                     put_bit(PORT_ONE_BIT, port_one_irq_flag_q) |
                     put_bit(PORT_ZERO_BIT, port_zero_irq_flag_q);
    img_frame_trig = put_bit(TRIG_EDGE_BIT, trig_edge_q);
    img_clk_edge   = put_bit(CLK_EDGE_BIT, clk_edge_q);
    img_low_limit  = {{(8-LOW_LIMIT_W){1'b0}}, low_limit_q};
    img_spread     = put_bit(SPREAD_ON_BIT, spread_on_q) |
                     put_bit(SPREAD_RATE_BIT, spread_rate_q);
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (!rsvd_hit) begin
      unique case (ADDR)
        INT_CTL_OFS:      rdata_d = img_int_ctl;
        INT_STS_OFS:      rdata_d = img_int_sts;
        FRAME_TRIG_OFS:   rdata_d = img_frame_trig;
        OUT_CLK_EDGE_OFS: rdata_d = img_clk_edge;
        CLK_LOW_THR_OFS:  rdata_d = img_low_limit;
        SPREAD_CTRL_OFS:  rdata_d = img_spread;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // Zero outside the answering cycle keeps stale data off the bus
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= '0;
    end else if (RD) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign RDATA = rdata_q;
endmodule

// ### dsocr_properties.sv
// Port-level concurrent checks for the configuration register bank
module dsocr_properties
  import dsocr_pkg::*;
(
  input wire logic          MCLK,        // Clock
  input wire logic          SYS_RST,     // Reset
  input wire logic    [7:0] ADDR,        // Address
  input wire logic    [7:0] WDATA,       // Write data
  input wire logic          WR,          // Write
  input wire logic          RD,          // Read
  input wire logic    [7:0] RDATA,       // Read data
  input wire logic          PORT0_EVENT, // Port 0 event
  input wire logic          PORT1_EVENT, // Port 1 event
  input wire dsocr_cfg_type CFG,         // Config
  input wire logic          GLOBAL_IRQ   // Global status
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Writes excluded: one may drop the enable on the same edge
  a_irq0_sets: assert property (
    PORT0_EVENT && CFG.port_zero_irq_enable && !WR |=> GLOBAL_IRQ) else $error("irq0");
  a_irq1_sets: assert property (
    PORT1_EVENT && CFG.port_one_irq_enable && !WR |=> GLOBAL_IRQ) else $error("irq1");
  a_trig_edge: assert property (WR && ADDR == FRAME_TRIG_OFS |=>
    CFG.frame_trigger_edge_sel == $past(WDATA[6])) else $error("trig");
  a_clk_edge: assert property (WR && ADDR == OUT_CLK_EDGE_OFS |=>
    CFG.output_clock_edge_sel == $past(WDATA[0])) else $error("clk");
  a_low_limit: assert property (WR && ADDR == CLK_LOW_THR_OFS |=>
    CFG.recovered_clock_low_limit == $past(WDATA[4:0])) else $error("limit");
  a_spread_on: assert property (WR && ADDR == SPREAD_CTRL_OFS |=>
    CFG.spread_modulation_on == $past(WDATA[4])) else $error("spread");
  a_rate_gates: assert property (
    !CFG.spread_modulation_rate |-> !CFG.spread_profile_valid) else $error("rate");
  a_rsvd_zero: assert property (RD && ADDR inside {[RSVD_A_LO_OFS:RSVD_A_HI_OFS]} |=>
    RDATA == 8'h00) else $error("rsvd");
endmodule
bind dsocr_regs dsocr_properties u_props (.*);

// ### deser_shared_output_config_regs_tb.sv
// Self-checking bench for the configuration register bank
module deser_shared_output_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0, STS_READ_PORT = 1'b0;
  logic PORT0_EVENT = 1'b0, PORT1_EVENT = 1'b0, GLOBAL_IRQ;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d;
  logic [7:0] ofs [5] = '{8'h25, 8'h3b, 8'h3c, 8'h3e, 8'h23};
  logic [7:0] msk [5] = '{8'h40, 8'h01, 8'h1f, 8'h11, 8'h83};
  logic [7:0] sh [5] = '{8'h00, 8'h01, 8'h14, 8'h00, 8'h00};
  dsocr_pkg::dsocr_cfg_type CFG;
  int n_errors = 0, check_count = 0, k;
  dsocr_regs uut (.*);
  always #5 MCLK = ~MCLK;
  initial begin
    repeat (5000) @(posedge MCLK);
    n_errors++;
    test_done;
  end
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) n_errors++;
    if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
  endtask
  function automatic logic [7:0] rd_exp(input int i, input logic [7:0] v);
    return v & msk[i];
  endfunction
  task automatic acc(input logic w, input logic [7:0] a, v);
    @(posedge MCLK);
    {WR, RD, ADDR, WDATA} <= {w, !w, a, v};
    @(posedge MCLK);
    {WR, RD} <= 2'b00;
    #1 if (!w) chk(RDATA, v);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h5fd5_be79));
    repeat (20) @(posedge MCLK);
    SYS_RST <= 1'b0;
    for (int a = 8'h26; a < 8'h4c; a++) begin
      if (a < 8'h3b || a > 8'h43) acc(1'b1, 8'(a), 8'hff);
      if (a < 8'h3b || a > 8'h43) acc(1'b0, 8'(a), 8'h00);
    end
    for (int i = 0; i < 5; i++) acc(1'b0, ofs[i], sh[i]);
    $display("reset and reserved done");
    repeat (40) begin
      k = $urandom_range(4);
      d = 8'($urandom);
      if (k == 3) d[4] = d[4] & sh[3][0];
      if (k == 3) d[0] = d[0] | sh[3][4] | d[4];
      acc(1'b1, ofs[k], d);
      sh[k] = rd_exp(k, d);
      acc(1'b0, ofs[k], sh[k]);
    end
    chk(8'(CFG.spread_profile_valid), 8'(sh[3][4] & sh[3][0]));
    chk(8'(CFG.recovered_clock_low_limit), sh[2]);
    $display("random access done");
    for (int n = 0; n < 2; n++) begin
      {PORT1_EVENT, PORT0_EVENT} <= 2'(1 << n);
      acc(1'b1, 8'h23, 8'(2 >> n));
      {PORT1_EVENT, PORT0_EVENT} <= 2'b00;
      acc(1'b0, 8'h24, 8'(1 << n));
      chk(8'(GLOBAL_IRQ), 8'h00);
      acc(1'b1, 8'h23, 8'(1 << n));
      {PORT1_EVENT, PORT0_EVENT} <= 2'(1 << n);
      STS_READ_PORT <= !n[0];
      acc(1'b0, 8'h4d, 8'h00);
      {PORT1_EVENT, PORT0_EVENT} <= 2'b00;
      acc(1'b0, 8'h24, 8'(8'h80 | (1 << n)));
      chk(8'(GLOBAL_IRQ), 8'h01);
      STS_READ_PORT <= n[0];
      acc(1'b0, 8'h4d + 8'(n), 8'h00);
      acc(1'b0, 8'h24, 8'h00);
      chk(8'(GLOBAL_IRQ), 8'h00);
    end
    $display("interrupt flags done");
    test_done;
  end
endmodule
